// file: pkg/pdm_pkg.sv
package pdm_pkg;
  // register byte addresses on the plain register port
  localparam logic [7:0] REG_PDCR = 8'h00;
  localparam logic [7:0] REG_MSTOP = 8'h04;
  localparam logic [7:0] REG_WDCS = 8'h08;
  localparam logic [7:0] REG_WDCNT = 8'h0c;
  localparam logic [7:0] REG_INTEVT = 8'h10;
  localparam logic [7:0] REG_PSTAT = 8'h14;
  // field positions
  localparam int STANDBY_SELECT_BIT_POS = 7;
  localparam int WDRUN_POS = 7;
  localparam int CKS_W = 3;
  localparam int PSTAT_LOW_POS = 8;
  localparam int PSTAT_UP_POS = 9;
  // module stop bits: low byte is the first stop group, high byte the second
  localparam int MODULE_STOP_BIT_W = 16;
  localparam logic [15:0] MODULE_STOP_BIT_RST = 16'h0000;
  localparam logic [15:0] MODULE_STOP_BIT_WMASK = 16'h7c2f;
  localparam logic [15:0] MODULE_STOP_BIT_INV = 16'h4000;
  localparam logic [15:0] MODULE_STOP_BIT_INIT = 16'h2008;
  localparam int MODULE_STOP_BIT_USB = 14;
  // watchdog settling timer
  localparam int CNT_W = 8;
  localparam int PRE_W = 11;
  localparam int PRESC_BASE = 4;
  localparam logic [7:0] WDCNT_RST = 8'h00;
  localparam logic [7:0] WDT_LOCK_CNT = 8'h80;
  localparam logic [2:0] CKS_RST = 3'h0;
  // interrupt event codes, values arbitrary
  localparam int EVT_W = 12;
  localparam logic [11:0] EVT_RST = 12'h000;
  localparam logic [11:0] EVT_NMI = 12'h010;
  localparam logic [11:0] EVT_IRQ = 12'h020;
  // power-down sequencer states
  typedef enum logic [6:0] {
    ST_RUN = 7'h01,
    ST_SLEEP = 7'h02,
    ST_STANDBY_SELECT_BIT = 7'h04,
    ST_SETTLE = 7'h08,
    ST_LOCK = 7'h10,
    ST_POR = 7'h20,
    ST_MRST = 7'h40
  } pdm_state_e;
endpackage : pdm_pkg

// file: rtl/pdm_settle_timer.sv
`timescale 1ns/1ps
`default_nettype none
module pdm_settle_timer
  import pdm_pkg::*;
#(
  parameter int CW = CNT_W,
  parameter int PW = PRE_W
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic run,
  input wire logic [CKS_W-1:0] cks,
  input wire logic cntWr,
  input wire logic [CW-1:0] cntWrData,
  output logic [CW-1:0] cnt,
  output logic ovf,
  output logic hitLock
);
  logic [PW-1:0] pre_q, pre_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic tick;

  // prescaler tick every 2^(cks+base) cycles; the clock select widens the settling window
  always_comb begin
    tick = run && (pre_q == PW'((1 << (int'(cks) + PRESC_BASE)) - 1));
    pre_d = run ? (tick ? '0 : pre_q + 1'b1) : '0;
    cnt_d = cnt_q;
    if (cntWr) begin
      cnt_d = cntWrData; // software write wins over a tick in the same cycle
    end else if (tick) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pre_q <= '0;
      cnt_q <= CW'(WDCNT_RST);
    end else begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
    end
  end

  // counter wrap ends settling; reaching the lock count re-enters standby
  assign cnt = cnt_q;
  assign ovf = tick && !cntWr && (cnt_q == '1);
  assign hitLock = tick && !cntWr && (cnt_q == CW'(WDT_LOCK_CNT - 8'h01));
endmodule : pdm_settle_timer
`default_nettype wire

// file: rtl/pdm_module_stop_bit_gate.sv
`timescale 1ns/1ps
`default_nettype none
module pdm_module_stop_bit_gate
  import pdm_pkg::*;
#(
  parameter int N = MODULE_STOP_BIT_W,
  parameter logic [N-1:0] INV = MODULE_STOP_BIT_INV,
  parameter logic [N-1:0] INIT = MODULE_STOP_BIT_INIT
) (
  input wire logic [N-1:0] stopBits,
  input wire logic clkRun,
  input wire logic stbyInit,
  output logic [N-1:0] clkEn,
  output logic [N-1:0] regInit
);
  // one gate per peripheral; inverted bits read 0 as stopped
  for (genvar i = 0; i < N; i++) begin : g_mod
    logic stopped;
    assign stopped = INV[i] ? !stopBits[i] : stopBits[i];
    assign clkEn[i] = clkRun && !stopped;
    assign regInit[i] = INIT[i] && (stopped || stbyInit);
  end
endmodule : pdm_module_stop_bit_gate
`default_nettype wire

// file: rtl/pdm_top.sv
// Overview of operation
// - halt with standby select clear enters sleep, cpu halted, registers kept
// - peripherals stay clocked in sleep; only the cpu stops
// - on-chip memory accesses are ignored during sleep, read data undefined
// - both clock output pins keep running during sleep
// - sleep drives upper status high, lower status low
// - nmi, irq, peripheral interrupt or reset leave sleep, block bit ignored
// - interrupt wake starts exception handling and loads the event code
// - halt with standby select set stops cpu, clocks, peripherals, clock pins
// - standby or module standby initializes adc and timer unit registers
// - standby drives upper status low, lower status high
// - nmi or irq edge restarts watchdog; clocks return after its interval
// - standby interrupt exit drives both status pins low before handling
// - clearing standby select stops watchdog; else it relocks standby at 80h
// - manual reset is ignored while standby select is set, except in standby itself
// - standby wake ignores the interrupt block bit
// - reset pins exit standby; clock output keeps running meanwhile
// - module stop bit set gates clock; usb bit inverted, zero at reset
// - clearing a stop bit or power-on reset ends module standby; usb writes one
// - power-on reset drives both status pins high, low once done
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module pdm_top
  import pdm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic porResetB,
  input wire logic manResetB,
  input wire logic haltExec,
  input wire logic nmiB,
  input wire logic irqB,
  input wire logic periphIntReq,
  input wire logic [EVT_W-1:0] periphIntCode,
  input wire logic memReq,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output logic cpuHalt,
  output logic cpuResetReq,
  output logic intTake,
  output logic [EVT_W-1:0] intEvtCode,
  output logic memAck,
  output logic memIgnored,
  output logic internalClkEn,
  output logic clkOutEn,
  output logic clkOut2En,
  output logic [MODULE_STOP_BIT_W-1:0] periphClkEn,
  output logic [MODULE_STOP_BIT_W-1:0] periphInit,
  output logic statusUpper,
  output logic statusLower
);
  pdm_state_e state_q, state_d;
  logic standby_select_bit_q, standby_select_bit_d;
  logic [MODULE_STOP_BIT_W-1:0] module_stop_bit_q, module_stop_bit_d;
  logic wdtRun_q, wdtRun_d;
  logic [CKS_W-1:0] cks_q, cks_d;
  logic [EVT_W-1:0] evt_q, evt_d;
  logic [EVT_W-1:0] pend_q, pend_d;
  logic take_q, take_d;
  logic statU_q, statU_d;
  logic statL_q, statL_d;
  logic nmiPrev_q, irqPrev_q;
  logic [31:0] rdata_q, rdata_d;
  logic resetAll, nmiEdge, irqEdge, manAccept, wakeSleep, wdtStart, stbyClear;
  logic inStandby, wrPdcr, wrMstop, wrWdcs, wrWdcnt;
  logic [CNT_W-1:0] wdtCnt;
  logic wdtOvf, wdtHit;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b || !porResetB);

  // power-on pin acts as a full reset alongside the system reset
  assign resetAll = !rst_b || !porResetB;
  assign nmiEdge = nmiB ^ nmiPrev_q;
  assign irqEdge = irqB ^ irqPrev_q;
  assign manAccept = !manResetB && (!standby_select_bit_q || state_q == ST_STANDBY_SELECT_BIT);
  // sleep wake sources, block bit not consulted
  assign wakeSleep = !nmiB || !irqB || periphIntReq;
  assign inStandby = (state_q == ST_STANDBY_SELECT_BIT) || (state_q == ST_SETTLE) || (state_q == ST_LOCK);

  // register write decode
  assign wrPdcr = regWr && (regAddr == REG_PDCR);
  assign wrMstop = regWr && (regAddr == REG_MSTOP);
  assign wrWdcs = regWr && (regAddr == REG_WDCS);
  assign wrWdcnt = regWr && (regAddr == REG_WDCNT);
  assign stbyClear = wrPdcr && standby_select_bit_q && !regWdata[STANDBY_SELECT_BIT_POS];

  // sequencer next state
  always_comb begin
    state_d = state_q;
    take_d = 1'b0;
    evt_d = evt_q;
    pend_d = pend_q;
    wdtStart = 1'b0;
    case (state_q)
      ST_POR: begin
        state_d = ST_RUN;
      end
      ST_RUN: begin
        if (manAccept) begin
          state_d = ST_MRST;
        end else if (haltExec) begin
          state_d = standby_select_bit_q ? ST_STANDBY_SELECT_BIT : ST_SLEEP;
        end else if (standby_select_bit_q && wdtRun_q && wdtHit) begin
          state_d = ST_LOCK;
        end
      end
      ST_SLEEP: begin
        if (manAccept) begin
          state_d = ST_MRST;
        end else if (wakeSleep) begin
          // wake with event code, nmi first
          state_d = ST_RUN;
          take_d = 1'b1;
          evt_d = !nmiB ? EVT_NMI : (!irqB ? EVT_IRQ : periphIntCode);
        end
      end
      ST_STANDBY_SELECT_BIT: begin
        if (manAccept) begin
          state_d = ST_MRST;
        end else if (nmiEdge || irqEdge) begin
          // edge restarts watchdog as settling timer
          state_d = ST_SETTLE;
          wdtStart = 1'b1;
          pend_d = nmiEdge ? EVT_NMI : EVT_IRQ;
        end
      end
      ST_SETTLE: begin
        if (wdtOvf) begin
          state_d = ST_RUN;
          take_d = 1'b1;
          evt_d = pend_q;
        end
      end
      ST_LOCK: begin
        state_d = ST_LOCK; // only a power-on or system reset gets out
      end
      ST_MRST: begin
        if (manResetB) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_POR;
      end
    endcase
  end

  // status pins follow the next state so they change with it
  always_comb begin
    statU_d = (state_d == ST_POR) || (state_d == ST_SLEEP);
    statL_d = (state_d == ST_POR) || (state_d == ST_STANDBY_SELECT_BIT) || (state_d == ST_SETTLE)
      || (state_d == ST_LOCK);
  end

  // software-visible control registers
  always_comb begin
    standby_select_bit_d = wrPdcr ? regWdata[STANDBY_SELECT_BIT_POS] : standby_select_bit_q;
    module_stop_bit_d = wrMstop ? (regWdata[MODULE_STOP_BIT_W-1:0] & MODULE_STOP_BIT_WMASK) : module_stop_bit_q;
    cks_d = wrWdcs ? regWdata[CKS_W-1:0] : cks_q;
    wdtRun_d = wdtRun_q;
    if (wdtStart) begin
      wdtRun_d = 1'b1; // hardware restart wins over a clear in the same cycle
    end else if (stbyClear) begin
      wdtRun_d = 1'b0;
    end else if (wrWdcs) begin
      wdtRun_d = regWdata[WDRUN_POS];
    end
  end

  // read data valid only in the cycle after the strobe; unmapped reads zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (regRd) begin
      case (regAddr)
        REG_PDCR: rdata_d[STANDBY_SELECT_BIT_POS] = standby_select_bit_q;
        REG_MSTOP: rdata_d[MODULE_STOP_BIT_W-1:0] = module_stop_bit_q;
        REG_WDCS: rdata_d = {24'h00_0000, wdtRun_q, 4'h0, cks_q};
        REG_WDCNT: rdata_d[CNT_W-1:0] = wdtCnt;
        REG_INTEVT: rdata_d[EVT_W-1:0] = evt_q;
        REG_PSTAT: rdata_d = {22'h00_0000, statU_q, statL_q, 1'b0, state_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (resetAll) begin
      state_q <= ST_POR;
      standby_select_bit_q <= 1'b0;
      // power-on clears stop bits, usb starts stopped
      module_stop_bit_q <= MODULE_STOP_BIT_RST;
      wdtRun_q <= 1'b0;
      cks_q <= CKS_RST;
      evt_q <= EVT_RST;
      pend_q <= EVT_RST;
      take_q <= 1'b0;
      statU_q <= 1'b1;
      statL_q <= 1'b1;
      nmiPrev_q <= 1'b1;
      irqPrev_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      standby_select_bit_q <= standby_select_bit_d;
      module_stop_bit_q <= module_stop_bit_d;
      wdtRun_q <= wdtRun_d;
      cks_q <= cks_d;
      evt_q <= evt_d;
      pend_q <= pend_d;
      take_q <= take_d;
      statU_q <= statU_d;
      statL_q <= statL_d;
      nmiPrev_q <= nmiB;
      irqPrev_q <= irqB;
      rdata_q <= rdata_d;
    end
  end

  pdm_settle_timer #(
    .CW(CNT_W),
    .PW(PRE_W)
  ) u_timer (
    .clk_sys(clk_sys),
    .rst_b(!resetAll),
    .run(wdtRun_q),
    .cks(cks_q),
    .cntWr(wrWdcnt),
    .cntWrData(regWdata[CNT_W-1:0]),
    .cnt(wdtCnt),
    .ovf(wdtOvf),
    .hitLock(wdtHit)
  );

  pdm_module_stop_bit_gate #(
    .N(MODULE_STOP_BIT_W),
    .INV(MODULE_STOP_BIT_INV),
    .INIT(MODULE_STOP_BIT_INIT)
  ) u_gate (
    .stopBits(module_stop_bit_q),
    .clkRun(internalClkEn),
    .stbyInit(inStandby),
    .clkEn(periphClkEn),
    .regInit(periphInit)
  );

  // clocks stop only in standby states
  assign internalClkEn = !inStandby;
  assign clkOutEn = !inStandby;
  assign clkOut2En = !inStandby;
  assign cpuHalt = (state_q != ST_RUN);
  assign cpuResetReq = (state_q == ST_MRST) || (state_q == ST_POR);
  assign memIgnored = (state_q == ST_SLEEP);
  assign memAck = memReq && (state_q != ST_SLEEP);
  assign intTake = take_q;
  assign intEvtCode = evt_q;
  assign statusUpper = statU_q;
  assign statusLower = statL_q;
  assign regRdata = rdata_q;

  sequence s_haltSleep;
    state_q == ST_RUN && haltExec && !standby_select_bit_q && !manAccept;
  endsequence
  sequence s_haltStby;
    state_q == ST_RUN && haltExec && standby_select_bit_q && !manAccept;
  endsequence
  sequence s_settleDone;
    state_q == ST_SETTLE && wdtOvf;
  endsequence

  property p_sleepEntry;
    s_haltSleep |=> state_q == ST_SLEEP && cpuHalt && statusUpper && !statusLower;
  endproperty
  a_sleepEntry: assert property (p_sleepEntry) else $error("halt did not enter sleep");
  property p_sleepClk;
    state_q == ST_SLEEP |-> internalClkEn && clkOutEn && clkOut2En;
  endproperty
  a_sleepClk: assert property (p_sleepClk) else $error("clocks stopped in sleep");
  property p_memIgn;
    state_q == ST_SLEEP |-> !memAck && memIgnored;
  endproperty
  a_memIgn: assert property (p_memIgn) else $error("memory answered in sleep");
  property p_stbyEntry;
    s_haltStby |=> state_q == ST_STANDBY_SELECT_BIT && !clkOutEn && !statusUpper && statusLower;
  endproperty
  a_stbyEntry: assert property (p_stbyEntry) else $error("halt did not enter standby");
  property p_settle;
    state_q == ST_STANDBY_SELECT_BIT && nmiEdge && !manAccept |=> state_q == ST_SETTLE && wdtRun_q;
  endproperty
  a_settle: assert property (p_settle) else $error("edge did not start settling");
  property p_wake;
    s_settleDone |=> intTake && !statusUpper && !statusLower && intEvtCode == $past(pend_q);
  endproperty
  a_wake: assert property (p_wake) else $error("standby wake wrong");
  property p_manIgn;
    state_q == ST_RUN && standby_select_bit_q |=> state_q != ST_MRST;
  endproperty
  a_manIgn: assert property (p_manIgn) else $error("manual reset taken with select set");
  property p_lock;
    state_q == ST_LOCK |=> state_q == ST_LOCK && !internalClkEn;
  endproperty
  a_lock: assert property (p_lock) else $error("relocked standby left");
  property p_usbGate;
    !module_stop_bit_q[MODULE_STOP_BIT_USB] |-> !periphClkEn[MODULE_STOP_BIT_USB];
  endproperty
  a_usbGate: assert property (p_usbGate) else $error("usb clocked while stopped");
  // reset must be sampled high, so the edge that still resets the flops is not judged
  property p_porDone;
    state_q == ST_POR && rst_b && porResetB |=> !statusUpper && !statusLower;
  endproperty
  a_porDone: assert property (p_porDone) else $error("status not low after reset");
  property p_sleepPeriph;
    state_q == ST_SLEEP |-> periphClkEn == ~(module_stop_bit_q ^ MODULE_STOP_BIT_INV);
  endproperty
  a_sleepPeriph: assert property (p_sleepPeriph) else $error("peripheral gated in sleep");
  property p_stbyPins;
    inStandby |-> !statusUpper && statusLower && !clkOutEn && !clkOut2En;
  endproperty
  a_stbyPins: assert property (p_stbyPins) else $error("standby pins wrong");
  property p_sleepWake;
    state_q == ST_SLEEP && wakeSleep && !manAccept |=> state_q == ST_RUN && intTake;
  endproperty
  a_sleepWake: assert property (p_sleepWake) else $error("interrupt did not leave sleep");
  property p_stbyMrst;
    state_q == ST_STANDBY_SELECT_BIT && !manResetB |=> state_q == ST_MRST && cpuResetReq && clkOutEn;
  endproperty
  a_stbyMrst: assert property (p_stbyMrst) else $error("reset pin did not leave standby");
  property p_selClear;
    stbyClear && !wdtStart |=> !wdtRun_q;
  endproperty
  a_selClear: assert property (p_selClear) else $error("watchdog kept running");
endmodule : pdm_top
`default_nettype wire

// file: verification/pdm_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// cpu halt pulse and interrupt pins as the far side drives them
module pdm_cpu_model (
  input wire logic clk_sys,
  input wire logic haltReq,
  input wire logic nmiTgl,
  input wire logic irqTgl,
  output logic haltExec,
  output logic nmiB,
  output logic irqB
);
  // pins idle high, both inactive
  initial begin
    haltExec = 1'b0;
    nmiB = 1'b1;
    irqB = 1'b1;
  end
  always @(posedge clk_sys) begin
    haltExec <= haltReq;
    if (nmiTgl) nmiB <= ~nmiB;
    if (irqTgl) irqB <= ~irqB;
  end
endmodule : pdm_cpu_model
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
  $display("Error at %0t: %h vs %h", $time, (a), (b)); end end
module tb_top;
  import pdm_pkg::*;
  logic clk_sys, rst_b, porResetB, manResetB, haltExec, nmiB, irqB;
  logic haltReq, nmiTgl, irqTgl, periphIntReq, memReq, regWr, regRd;
  logic [EVT_W-1:0] periphIntCode, evt;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, rv, seed, v;
  logic cpuHalt, cpuResetReq, intTake, memAck, memIgnored;
  logic internalClkEn, clkOutEn, clkOut2En, statusUpper, statusLower;
  logic [EVT_W-1:0] intEvtCode;
  logic [MODULE_STOP_BIT_W-1:0] periphClkEn, periphInit, m, stp;
  int failures, compares, cyc, n;
  pdm_top pdm_top_inst (.clk_sys(clk_sys), .rst_b(rst_b), .porResetB(porResetB),
    .manResetB(manResetB), .haltExec(haltExec), .nmiB(nmiB), .irqB(irqB),
    .periphIntReq(periphIntReq), .periphIntCode(periphIntCode), .memReq(memReq),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .cpuHalt(cpuHalt), .cpuResetReq(cpuResetReq),
    .intTake(intTake), .intEvtCode(intEvtCode), .memAck(memAck),
    .memIgnored(memIgnored), .internalClkEn(internalClkEn), .clkOutEn(clkOutEn),
    .clkOut2En(clkOut2En), .periphClkEn(periphClkEn), .periphInit(periphInit),
    .statusUpper(statusUpper), .statusLower(statusLower));
  pdm_cpu_model pdm_cpu_model_inst (.clk_sys(clk_sys), .haltReq(haltReq),
    .nmiTgl(nmiTgl), .irqTgl(irqTgl), .haltExec(haltExec), .nmiB(nmiB), .irqB(irqB));
  // 250 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic end_of_test();
    if (failures == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  // a hang counts as a mismatch
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      end_of_test();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask : rd
  task automatic halt();
    @(posedge clk_sys);
    haltReq <= 1'b1;
    @(posedge clk_sys);
    haltReq <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask : halt
  task automatic pulse(input int k);
    @(posedge clk_sys);
    nmiTgl <= (k == 0);
    irqTgl <= (k == 1);
    @(posedge clk_sys);
    nmiTgl <= 1'b0;
    irqTgl <= 1'b0;
  endtask : pulse
  // sel 0 waits for intTake, sel 1 for the internal clock to stop
  task automatic waitFor(input int sel, input int lim, output int c);
    c = 0;
    while (c < lim && (sel ? internalClkEn !== 1'b0 : intTake !== 1'b1)) begin
      @(posedge clk_sys);
      #1 c++;
    end
    if (c >= lim) failures++;
  endtask : waitFor
  // watchdog stopped, zeroed, fastest clock, then select and halt
  task automatic enterStby();
    wr(REG_WDCS, 32'h0);
    wr(REG_WDCNT, 32'h0);
    wr(REG_PDCR, 32'h80);
    halt();
  endtask : enterStby
  initial begin
    seed = 32'd95545;
    {rst_b, haltReq, nmiTgl, irqTgl, periphIntReq, memReq, regWr, regRd} = '0;
    {porResetB, manResetB} = 2'h3;
    periphIntCode = '0;
    regAddr = '0;
    regWdata = '0;
    failures = 0;
    compares = 0;
    cyc = 0;
    @(posedge clk_sys);
    #1 `CHK({statusUpper, statusLower}, 2'h3)
    @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    #1 `CHK({statusUpper, statusLower}, 2'h0)
    `CHK(periphClkEn[MODULE_STOP_BIT_USB], 1'b0)
    rd(REG_MSTOP, rv);
    `CHK(rv, 32'h0)
    rd(8'hfc, rv);
    `CHK(rv, 32'h0)
    // module stop bits: random writes, read back before relying on them
    // no peripheral register is touched while its module is stopped
    for (int i = 0; i < 6; i++) begin
      v = xs();
      wr(REG_MSTOP, v);
      rd(REG_MSTOP, rv);
      m = v[15:0] & MODULE_STOP_BIT_WMASK;
      stp = m ^ MODULE_STOP_BIT_INV;
      `CHK(rv, {16'h0, m})
      `CHK(periphClkEn, ~stp)
      `CHK(periphInit, stp & MODULE_STOP_BIT_INIT)
    end
    wr(REG_MSTOP, 32'h4000);
    wr(REG_PDCR, 32'h0);
    memReq <= 1'b1;
    // sleep entry and each wake source
    for (int k = 0; k < 3; k++) begin
      #1 `CHK(memAck, 1'b1)
      halt();
      `CHK({cpuHalt, memAck, memIgnored}, 3'h5)
      `CHK({statusUpper, statusLower}, 2'h2)
      `CHK({clkOutEn, clkOut2En}, 2'h3)
      `CHK(periphClkEn, 16'hffff)
      evt = EVT_W'(xs());
      if (k == 2) begin
        @(posedge clk_sys);
        periphIntReq <= 1'b1;
        periphIntCode <= evt;
      end else pulse(k);
      waitFor(0, 20, n);
      `CHK(intEvtCode, k == 0 ? EVT_NMI : k == 1 ? EVT_IRQ : evt)
      `CHK({statusUpper, statusLower, cpuHalt}, 3'h0)
      pulse(k == 2 ? 3 : k);
      periphIntReq <= 1'b0;
    end
    memReq <= 1'b0;
    // manual reset also leaves sleep
    halt();
    manResetB <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 `CHK({cpuResetReq, statusUpper, statusLower}, 3'h4)
    manResetB <= 1'b1;
    // select set in run: manual reset refused
    wr(REG_WDCS, 32'h0);
    wr(REG_WDCNT, 32'h0);
    wr(REG_PDCR, 32'h80);
    manResetB <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 `CHK(cpuResetReq, 1'b0)
    manResetB <= 1'b1;
    halt();
    `CHK({internalClkEn, clkOutEn, clkOut2En, cpuHalt}, 4'h1)
    `CHK({statusUpper, statusLower}, 2'h1)
    `CHK(periphInit, MODULE_STOP_BIT_INIT)
    // settling: 256 ticks of 16 cycles before clocks return
    pulse(0);
    waitFor(0, 6000, n);
    `CHK(n >= 4000 && n <= 4200, 1'b1)
    `CHK({statusUpper, statusLower}, 2'h0)
    `CHK(intEvtCode, EVT_NMI)
    `CHK(internalClkEn, 1'b1)
    // select left set: watchdog relocks at 80h, only power-on or system reset exits
    waitFor(1, 2600, n);
    `CHK(n >= 1900 && n <= 2200, 1'b1)
    manResetB <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 `CHK({cpuResetReq, cpuHalt}, 2'h1)
    manResetB <= 1'b1;
    porResetB <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 `CHK({cpuResetReq, statusUpper, statusLower}, 3'h7)
    porResetB <= 1'b1;
    pulse(0);
    // clearing select after wake stops the watchdog
    enterStby();
    pulse(1);
    waitFor(0, 6000, n);
    `CHK(intEvtCode, EVT_IRQ)
    wr(REG_PDCR, 32'h0);
    rd(REG_WDCS, rv);
    `CHK(rv[WDRUN_POS], 1'b0)
    repeat (2500) @(posedge clk_sys);
    #1 `CHK(internalClkEn, 1'b1)
    pulse(1);
    // reset pin held low exits standby with clock output on
    enterStby();
    manResetB <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 `CHK({cpuResetReq, clkOutEn}, 2'h3)
    manResetB <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 `CHK(cpuHalt, 1'b0)
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
